// >>> include/sot_pkg.sv
package sot_pkg;

	// ----------------------------------------------------------------
	// Request encodings
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_SUM,
		OP_DIFFERENCE,
		OP_AND,
		OP_OR,
		OP_COMPARE,
		OP_EXCL_DISJ,
		OP_SIGNED_DIVIDE,
		OP_UNSIGNED_DIVIDE,
		OP_SIGNED_MULTIPLY,
		OP_UNSIGNED_MULTIPLY
	} sot_op_t;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} sot_size_t;
	typedef enum logic [1:0] {DEST_ADDR_REG, DEST_DATA_REG, DEST_MEMORY} sot_dest_t;
	typedef enum logic [1:0] {LOOP_CONTINUE, LOOP_TRUE, LOOP_EXPIRED} sot_loop_end_t;
	typedef enum logic [1:0] {EA_OTHER, EA_INDIRECT, EA_POSTINC, EA_PREDEC} sot_ea_mode_t;

	// ----------------------------------------------------------------
	// Widths and entry layout {clocks[15:8], reads[7:4], writes[3:0]}
	// ----------------------------------------------------------------
	localparam int OP_COUNT = 10;
	localparam int CLK_W = 9;
	localparam int BUS_W = 5;
	localparam int ENT_CLK_LSB = 8;
	localparam int ENT_RD_LSB = 4;
	localparam int ENT_WR_LSB = 0;
	localparam logic [15:0] ENT_NONE = 16'h0000;
	localparam logic [15:0] MUL_REG_SRC_ENTRY = 16'h2810;
	localparam logic [8:0] PREDEC_EXTRA_CLK = 9'h002;
	localparam logic [8:0] CNT_RESET = 9'h000;

	// ----------------------------------------------------------------
	// Normal mode: [op][long][dest]
	// ----------------------------------------------------------------
	localparam logic [15:0] NORM_TAB [OP_COUNT][2][3] = '{
		'{'{16'h0810, 16'h0410, 16'h0811}, '{16'h0610, 16'h0610, 16'h0C12}},
		'{'{16'h0810, 16'h0410, 16'h0811}, '{16'h0610, 16'h0610, 16'h0C12}},
		'{'{16'h0000, 16'h0410, 16'h0811}, '{16'h0000, 16'h0610, 16'h0C12}},
		'{'{16'h0000, 16'h0410, 16'h0811}, '{16'h0000, 16'h0610, 16'h0C12}},
		'{'{16'h0610, 16'h0410, 16'h0000}, '{16'h0610, 16'h0610, 16'h0000}},
		'{'{16'h0000, 16'h0410, 16'h0811}, '{16'h0000, 16'h0610, 16'h0C12}},
		'{'{16'h0000, 16'h7A10, 16'h0000}, '{16'h0000, 16'h7A10, 16'h0000}},
		'{'{16'h0000, 16'h6C10, 16'h0000}, '{16'h0000, 16'h6C10, 16'h0000}},
		'{'{16'h0000, 16'h2A10, 16'h0000}, '{16'h0000, 16'h2A10, 16'h0000}},
		'{'{16'h0000, 16'h2A10, 16'h0000}, '{16'h0000, 16'h2A10, 16'h0000}}
	};

	// ----------------------------------------------------------------
	// Loop mode: [op][long][dest][continue, true, expired]
	// ----------------------------------------------------------------
	localparam logic [15:0] LOOP_TAB [OP_COUNT][2][3][3] = '{
		'{'{'{16'h1210, 16'h1830, 16'h1630}, '{16'h1010, 16'h1630, 16'h1430}, '{16'h1011, 16'h1631, 16'h1431}},
			'{'{16'h1620, 16'h1C40, 16'h1A40}, '{16'h1620, 16'h1C40, 16'h1A40}, '{16'h1822, 16'h1E42, 16'h1C42}}},
		'{'{'{16'h1210, 16'h1830, 16'h1630}, '{16'h1010, 16'h1630, 16'h1430}, '{16'h1011, 16'h1631, 16'h1431}},
			'{'{16'h1620, 16'h1C40, 16'h1A40}, '{16'h1420, 16'h1A40, 16'h1840}, '{16'h1822, 16'h1E42, 16'h1C42}}},
		'{'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h1010, 16'h1630, 16'h1430}, '{16'h1011, 16'h1631, 16'h1431}},
			'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h1620, 16'h1C40, 16'h1A40}, '{16'h1822, 16'h1E42, 16'h1C42}}},
		'{'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h1010, 16'h1630, 16'h1430}, '{16'h1010, 16'h1631, 16'h1431}},
			'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h1620, 16'h1C40, 16'h1A40}, '{16'h1822, 16'h1E42, 16'h1C42}}},
		'{'{'{16'h0C10, 16'h1230, 16'h1030}, '{16'h0C10, 16'h1230, 16'h1040}, '{16'h0000, 16'h0000, 16'h0000}},
			'{'{16'h1220, 16'h1840, 16'h1440}, '{16'h1220, 16'h1840, 16'h1440}, '{16'h0000, 16'h0000, 16'h0000}}},
		'{'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h0000, 16'h0000, 16'h0000}, '{16'h1010, 16'h1631, 16'h1431}},
			'{'{16'h0000, 16'h0000, 16'h0000}, '{16'h0000, 16'h0000, 16'h0000}, '{16'h1822, 16'h1E42, 16'h1C42}}},
		'{default: 16'h0000},
		'{default: 16'h0000},
		'{default: 16'h0000},
		'{default: 16'h0000}
	};

endpackage : sot_pkg

// >>> hw/sot_countdown.sv
`timescale 1ns/1ps
module sot_countdown
	import sot_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Load
	input wire logic load_i,
	input wire logic [CLK_W-1:0] load_val_i,
	// Status
	output logic busy_o,
	output logic done_o
);

	logic [CLK_W-1:0] cnt;
	logic [CLK_W-1:0] next_cnt;

	always_comb begin
		if (load_i) begin
			next_cnt = load_val_i;
		end else if (cnt != CNT_RESET) begin
			next_cnt = cnt - 9'h001;
		end else begin
			next_cnt = CNT_RESET;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= CNT_RESET;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign busy_o = (cnt != CNT_RESET);
	assign done_o = (cnt == 9'h001);

	done_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |=> !done_o) // R3
		else $error("done pulse longer than one cycle");

endmodule : sot_countdown

// >>> hw/sot_timing.sv
`timescale 1ns/1ps
// Functional notes
// (R1) Every answer gives total clocks, bus reads and bus writes together.
// (R2) Flagged entries add the operand address clocks, reads and writes to each count.
// (R3) Counts cover the operation, result write-back and next instruction fetch.
// (R4) Immediate forms include operand fetch; they are not timed by this table.
// (R5) Sum/difference: data dest 4 or 6 (1/0), memory 8(1/1) or 12(1/2), plus address.
// (R6) Into address register: word 8, long 6, one read; compare 6 either size.
// (R7) Signed divide 122, unsigned divide 108 clocks, one read, plus address time.
// (R8) Multiply takes 42 clocks with one read plus address; 40 variant without.
// (R9) Exclusive-or into data register needs data register source: 4 or 6 clocks.
// (R10) Loop mode allows indirect, postincrement, predecrement only; predecrement adds two.
// (R11) Loop sum into address register: 18 continue, 24 true, 22 expired.
// (R12) Loop compare: 12 (1 read) continue, 18 (3 reads) true, 16 expired.
// (R13) Address register destinations take word or long size only.
module sot_timing
	import sot_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Request
	input wire logic req_i,
	input sot_op_t op_i,
	input sot_size_t size_i,
	input sot_dest_t dest_i,
	input wire logic src_data_reg_i,
	input wire logic loop_i,
	input sot_loop_end_t loop_end_i,
	input sot_ea_mode_t ea_mode_i,
	// Operand address calculation counts
	input wire logic [7:0] ea_clk_i,
	input wire logic [3:0] ea_rd_i,
	input wire logic [3:0] ea_wr_i,
	// Answer
	output logic ack_o,
	output logic illegal_o,
	output logic [CLK_W-1:0] clk_cnt_o,
	output logic [BUS_W-1:0] rd_cnt_o,
	output logic [BUS_W-1:0] wr_cnt_o,
	// Execution tracking
	output logic busy_o,
	output logic done_o
);

	// ----------------------------------------------------------------
	// Table lookup
	// ----------------------------------------------------------------
	function automatic logic [15:0] sot_entry(sot_op_t op, logic lng, sot_dest_t dest, logic loop,
		sot_loop_end_t le);
		logic [15:0] e;
		e = ENT_NONE;
		// Out-of-range codes fall back to no entry, hence refused
		// Loop end code only matters in loop mode
		if (op < OP_COUNT && dest <= DEST_MEMORY && (!loop || le <= LOOP_EXPIRED)) begin
			if (loop) begin
				e = LOOP_TAB[op][lng][dest][le]; // R11 R12
			end else begin
				e = NORM_TAB[op][lng][dest]; // R5 R6 R7
			end
		end
		return e;
	endfunction : sot_entry

	logic accept;
	logic legal;
	logic add_ea;
	logic is_muldiv;
	logic is_mul;
	logic [15:0] ent;
	logic [CLK_W-1:0] sum_clk;
	logic [BUS_W-1:0] sum_rd;
	logic [BUS_W-1:0] sum_wr;
	logic next_ack;
	logic next_illegal;
	logic [CLK_W-1:0] next_clk_cnt;
	logic [BUS_W-1:0] next_rd_cnt;
	logic [BUS_W-1:0] next_wr_cnt;

	// Only one instruction timed at a time; requests while busy are dropped
	assign accept = req_i && !busy_o;

	always_comb begin
		is_mul = (op_i == OP_SIGNED_MULTIPLY) || (op_i == OP_UNSIGNED_MULTIPLY);
		is_muldiv = is_mul || (op_i == OP_SIGNED_DIVIDE) || (op_i == OP_UNSIGNED_DIVIDE);
		ent = sot_entry(op_i, size_i == SZ_LONG, dest_i, loop_i, loop_end_i);
		add_ea = !loop_i; // R2
		// Flat 40 variant exists only into a data register
		if (!loop_i && is_mul && src_data_reg_i && dest_i == DEST_DATA_REG) begin
			ent = MUL_REG_SRC_ENTRY; // R8
			add_ea = 1'b0;
		end
		if (op_i == OP_EXCL_DISJ && dest_i == DEST_DATA_REG) begin
			add_ea = 1'b0; // R9
		end
		// Immediate forms are not in this set, so no code maps to them
		legal = (ent != ENT_NONE); // R4
		if (!(size_i inside {SZ_BYTE, SZ_WORD, SZ_LONG})) begin
			legal = 1'b0;
		end
		if (dest_i == DEST_ADDR_REG && size_i == SZ_BYTE) begin
			legal = 1'b0; // R13
		end
		if (op_i == OP_EXCL_DISJ && dest_i == DEST_DATA_REG && !src_data_reg_i) begin
			legal = 1'b0; // R9
		end
		if (is_muldiv && size_i != SZ_WORD) begin
			legal = 1'b0;
		end
		if (loop_i && ea_mode_i == EA_OTHER) begin
			legal = 1'b0; // R10
		end
		// Base counts already cover operate, write back and next fetch
		sum_clk = {1'b0, ent[ENT_CLK_LSB +: 8]}; // R3
		sum_rd = {1'b0, ent[ENT_RD_LSB +: 4]};
		sum_wr = {1'b0, ent[ENT_WR_LSB +: 4]};
		if (add_ea) begin
			sum_clk = sum_clk + {1'b0, ea_clk_i}; // R2
			sum_rd = sum_rd + {1'b0, ea_rd_i};
			sum_wr = sum_wr + {1'b0, ea_wr_i};
		end
		if (loop_i && ea_mode_i == EA_PREDEC) begin
			sum_clk = sum_clk + PREDEC_EXTRA_CLK; // R10
		end
	end

	// ----------------------------------------------------------------
	// Answer registers
	// ----------------------------------------------------------------
	always_comb begin
		next_ack = accept;
		next_illegal = illegal_o;
		next_clk_cnt = clk_cnt_o;
		next_rd_cnt = rd_cnt_o;
		next_wr_cnt = wr_cnt_o;
		if (accept) begin
			next_illegal = !legal;
			// Refused requests report zero rather than a stale figure
			next_clk_cnt = legal ? sum_clk : CNT_RESET; // R1
			next_rd_cnt = legal ? sum_rd : 5'h00;
			next_wr_cnt = legal ? sum_wr : 5'h00;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			illegal_o <= 1'b0;
			clk_cnt_o <= CNT_RESET;
			rd_cnt_o <= 5'h00;
			wr_cnt_o <= 5'h00;
		end else begin
			ack_o <= next_ack;
			illegal_o <= next_illegal;
			clk_cnt_o <= next_clk_cnt;
			rd_cnt_o <= next_rd_cnt;
			wr_cnt_o <= next_wr_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Execution time tracker
	// ----------------------------------------------------------------
	sot_countdown u_countdown (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(accept && legal),
		.load_val_i(sum_clk),
		.busy_o(busy_o),
		.done_o(done_o)
	);

	ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		accept |=> ack_o && (illegal_o || clk_cnt_o != CNT_RESET))
		else $error("accepted request not answered with counts");

	addr_byte_refused_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		accept && dest_i == DEST_ADDR_REG && size_i == SZ_BYTE |=> illegal_o)
		else $error("byte size into address register accepted");

	sum_data_word_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		accept && op_i == OP_SUM && !loop_i && dest_i == DEST_DATA_REG && size_i == SZ_WORD
		|=> clk_cnt_o == 9'(9'h004 + $past(ea_clk_i)) && rd_cnt_o == 5'(5'h01 + $past(ea_rd_i))
		&& wr_cnt_o == 5'($past(ea_wr_i)))
		else $error("word sum into data register miscounted");

	sum_addr_word_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		accept && op_i == OP_SUM && !loop_i && dest_i == DEST_ADDR_REG && size_i == SZ_WORD
		|=> clk_cnt_o == 9'(9'h008 + $past(ea_clk_i)))
		else $error("word sum into address register miscounted");

	divide_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		accept && op_i == OP_SIGNED_DIVIDE && !loop_i && dest_i == DEST_DATA_REG && size_i == SZ_WORD
		|=> clk_cnt_o == 9'(9'h07A + $past(ea_clk_i)) && !illegal_o)
		else $error("signed divide miscounted");

	multiply_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		accept && is_mul && !loop_i && dest_i == DEST_DATA_REG && size_i == SZ_WORD
		|=> clk_cnt_o == ($past(src_data_reg_i) ? 9'h028 : 9'(9'h02A + $past(ea_clk_i))))
		else $error("multiply miscounted");

	excl_source_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		accept && op_i == OP_EXCL_DISJ && dest_i == DEST_DATA_REG && !src_data_reg_i |=> illegal_o)
		else $error("exclusive-or from non data register accepted");

	loop_mode_ea_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		accept && loop_i && ea_mode_i == EA_OTHER |=> illegal_o ##1 !busy_o)
		else $error("loop mode accepted unsupported addressing");

	loop_sum_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		accept && loop_i && op_i == OP_SUM && dest_i == DEST_ADDR_REG && size_i == SZ_WORD
		&& ea_mode_i == EA_PREDEC && loop_end_i == LOOP_TRUE |=> clk_cnt_o == 9'h01A)
		else $error("loop sum into address register miscounted");

	loop_compare_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		accept && loop_i && op_i == OP_COMPARE && dest_i == DEST_DATA_REG && size_i == SZ_BYTE
		&& ea_mode_i == EA_INDIRECT && loop_end_i == LOOP_TRUE |=> clk_cnt_o == 9'h012 && rd_cnt_o == 5'h03)
		else $error("loop compare miscounted");

	busy_span_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		ack_o && !illegal_o && clk_cnt_o == 9'h004 |-> busy_o [*4] ##1 !busy_o)
		else $error("busy span differs from clock count");

endmodule : sot_timing

// >>> dv/test_sot_timing.sv
`timescale 1ns/1ps
module test_sot_timing
	import sot_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus and observation
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_i = 1'b0;
	sot_op_t op_i = OP_SUM;
	sot_size_t size_i = SZ_WORD;
	sot_dest_t dest_i = DEST_DATA_REG;
	logic src_data_reg_i = 1'b0;
	logic loop_i = 1'b0;
	sot_loop_end_t loop_end_i = LOOP_CONTINUE;
	sot_ea_mode_t ea_mode_i = EA_OTHER;
	logic [7:0] ea_clk_i = 8'h00;
	logic [3:0] ea_rd_i = 4'h0;
	logic [3:0] ea_wr_i = 4'h0;
	logic ack_o, illegal_o, busy_o, done_o;
	logic [CLK_W-1:0] clk_cnt_o;
	logic [BUS_W-1:0] rd_cnt_o, wr_cnt_o;
	int fail_count = 0;
	int check_count = 0;

	sot_timing u_sot_timing (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i), .size_i(size_i), .dest_i(dest_i),
		.src_data_reg_i(src_data_reg_i), .loop_i(loop_i), .loop_end_i(loop_end_i), .ea_mode_i(ea_mode_i),
		.ea_clk_i(ea_clk_i), .ea_rd_i(ea_rd_i), .ea_wr_i(ea_wr_i), .ack_o(ack_o), .illegal_o(illegal_o),
		.clk_cnt_o(clk_cnt_o), .rd_cnt_o(rd_cnt_o), .wr_cnt_o(wr_cnt_o), .busy_o(busy_o), .done_o(done_o)
	);

	always #50 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	// Poke raises a second request mid-run; it must be ignored while busy
	task automatic go(input sot_op_t o, input sot_size_t s, input sot_dest_t d, input logic sr, lp,
		input sot_loop_end_t le, input sot_ea_mode_t em, input logic [7:0] c, input logic [3:0] r, w,
		input logic ill, input logic [8:0] ec, input logic [4:0] er, ew, input logic pk);
		int n;
		int dp;
		int a;
		int k;
		op_i = o;
		size_i = s;
		dest_i = d;
		src_data_reg_i = sr;
		loop_i = lp;
		loop_end_i = le;
		ea_mode_i = em;
		ea_clk_i = c;
		ea_rd_i = r;
		ea_wr_i = w;
		req_i = 1'b1;
		@(negedge clk_i);
		req_i = 1'b0;
		k = 0;
		while (ack_o !== 1'b1 && k < 4) begin
			k++;
			@(negedge clk_i);
		end
		check("ack delay", 16'(k), 16'h0000);
		check("illegal", 16'(illegal_o), 16'(ill));
		check("clocks", 16'(clk_cnt_o), 16'(ec));
		check("reads", 16'(rd_cnt_o), 16'(er));
		check("writes", 16'(wr_cnt_o), 16'(ew));
		n = 0;
		dp = 0;
		a = 0;
		while (busy_o === 1'b1 && n < 300) begin
			n++;
			if (done_o === 1'b1) dp = n;
			if (ack_o === 1'b1) a++;
			if (pk && (n == 2 || n == 3)) req_i = (n == 2);
			@(negedge clk_i);
		end
		check("busy cycles", 16'(n), ill ? 16'h0000 : 16'(ec));
		check("done position", 16'(dp), ill ? 16'h0000 : 16'(ec));
		check("acks", 16'(a), ill ? 16'h0000 : 16'h0001);
		@(negedge clk_i);
	endtask : go

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_sum;
		go(OP_SUM, SZ_WORD, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h04, 4'h1, 4'h0, 0, 9'h008, 5'h02, 5'h00, 0);
		go(OP_DIFFERENCE, SZ_LONG, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 0, 9'h006, 5'h01, 5'h00, 0);
		go(OP_SUM, SZ_BYTE, DEST_MEMORY, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h1, 0, 9'h00A, 5'h02, 5'h02, 0);
		go(OP_DIFFERENCE, SZ_LONG, DEST_MEMORY, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h1, 0, 9'h00E, 5'h02, 5'h03, 0);
	endtask : t_sum

	task automatic t_addr;
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h0, 0, 9'h00A, 5'h02, 5'h00, 0);
		go(OP_DIFFERENCE, SZ_LONG, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 0, 9'h006, 5'h01, 5'h00, 0);
		go(OP_COMPARE, SZ_WORD, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 0, 9'h006, 5'h01, 5'h00, 0);
		go(OP_COMPARE, SZ_LONG, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 0, 9'h006, 5'h01, 5'h00, 0);
		go(OP_SUM, SZ_BYTE, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_COMPARE, SZ_BYTE, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
	endtask : t_addr

	task automatic t_divmul;
		go(OP_SIGNED_DIVIDE, SZ_WORD, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 0, 9'h07A, 5'h01, 5'h00, 1);
		go(OP_UNSIGNED_DIVIDE, SZ_WORD, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h04, 4'h1, 4'h0, 0, 9'h070, 5'h02, 5'h00, 0);
		go(OP_SIGNED_MULTIPLY, SZ_WORD, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h0, 0, 9'h02C, 5'h02, 5'h00, 0);
		go(OP_UNSIGNED_MULTIPLY, SZ_WORD, DEST_DATA_REG, 1, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h0, 0, 9'h028, 5'h01, 5'h00, 0);
		go(OP_SIGNED_MULTIPLY, SZ_WORD, DEST_ADDR_REG, 1, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
	endtask : t_divmul

	task automatic t_xor;
		go(OP_EXCL_DISJ, SZ_BYTE, DEST_DATA_REG, 1, 0, LOOP_CONTINUE, EA_OTHER,
			8'h04, 4'h1, 4'h0, 0, 9'h004, 5'h01, 5'h00, 0);
		go(OP_EXCL_DISJ, SZ_LONG, DEST_DATA_REG, 1, 0, LOOP_CONTINUE, EA_OTHER,
			8'h04, 4'h1, 4'h0, 0, 9'h006, 5'h01, 5'h00, 0);
		go(OP_EXCL_DISJ, SZ_WORD, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
	endtask : t_xor

	task automatic t_logic;
		go(OP_AND, SZ_WORD, DEST_MEMORY, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h04, 4'h1, 4'h0, 0, 9'h00C, 5'h02, 5'h01, 0);
		go(OP_OR, SZ_LONG, DEST_DATA_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h02, 4'h1, 4'h0, 0, 9'h008, 5'h02, 5'h00, 0);
		go(OP_AND, SZ_WORD, DEST_ADDR_REG, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_COMPARE, SZ_WORD, DEST_MEMORY, 0, 0, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_OR, SZ_BYTE, DEST_MEMORY, 0, 1, LOOP_CONTINUE, EA_POSTINC,
			8'h04, 4'h1, 4'h0, 0, 9'h010, 5'h01, 5'h00, 0);
		go(OP_EXCL_DISJ, SZ_LONG, DEST_MEMORY, 0, 1, LOOP_EXPIRED, EA_POSTINC,
			8'h04, 4'h1, 4'h0, 0, 9'h01C, 5'h04, 5'h02, 0);
	endtask : t_logic

	task automatic t_loop;
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_CONTINUE, EA_INDIRECT,
			8'h04, 4'h1, 4'h0, 0, 9'h012, 5'h01, 5'h00, 0);
		go(OP_SUM, SZ_BYTE, DEST_ADDR_REG, 0, 1, LOOP_TRUE, EA_POSTINC,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_DIFFERENCE, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_TRUE, EA_POSTINC,
			8'h00, 4'h0, 4'h0, 0, 9'h018, 5'h03, 5'h00, 0);
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_EXPIRED, EA_INDIRECT,
			8'h00, 4'h0, 4'h0, 0, 9'h016, 5'h03, 5'h00, 0);
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_CONTINUE, EA_PREDEC,
			8'h00, 4'h0, 4'h0, 0, 9'h014, 5'h01, 5'h00, 0);
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_TRUE, EA_PREDEC,
			8'h00, 4'h0, 4'h0, 0, 9'h01A, 5'h03, 5'h00, 0);
		go(OP_SUM, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_CONTINUE, EA_OTHER,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_COMPARE, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_CONTINUE, EA_INDIRECT,
			8'h00, 4'h0, 4'h0, 0, 9'h00C, 5'h01, 5'h00, 0);
		go(OP_COMPARE, SZ_BYTE, DEST_ADDR_REG, 0, 1, LOOP_TRUE, EA_INDIRECT,
			8'h00, 4'h0, 4'h0, 1, 9'h000, 5'h00, 5'h00, 0);
		go(OP_COMPARE, SZ_BYTE, DEST_DATA_REG, 0, 1, LOOP_TRUE, EA_INDIRECT,
			8'h00, 4'h0, 4'h0, 0, 9'h012, 5'h03, 5'h00, 0);
		go(OP_COMPARE, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_TRUE, EA_POSTINC,
			8'h00, 4'h0, 4'h0, 0, 9'h012, 5'h03, 5'h00, 0);
		go(OP_COMPARE, SZ_WORD, DEST_ADDR_REG, 0, 1, LOOP_EXPIRED, EA_PREDEC,
			8'h00, 4'h0, 4'h0, 0, 9'h012, 5'h03, 5'h00, 0);
	endtask : t_loop

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		t_sum();
		t_addr();
		t_divmul();
		t_xor();
		t_logic();
		t_loop();
		complete_run();
	end

	// About 700 cycles of work; ample margin before giving up
	initial begin
		#2000000;
		fail_count++;
		complete_run();
	end

endmodule : test_sot_timing
